// file: core/gp6_port.sv
// Function
// - six pins, one port data register
// - per-pin direction bit decides direction
// - per-pin pull-up when pin is input
// - pull-downs pins 0-3 from bits 7:4
// - per-pin open-drain; pin 3 always open-drain
// - selected pin change sets level-change flag
// - request needs flag, enable and global enable
// - external interrupt input on pin 0
// - external interrupt masks pin 0 change
// - ir carrier out on pin 1
// - pin 3 low resets when option set
// - instruction clock on pin 4 option
// - pin 2 feeds timer external clocks
// - pwm or buzzer waveform on pin 2
// - read returns pin or output latch
`timescale 1ns/1ps
module gp6_port
  import gp6_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire gp6_av_req_t av_req,
  output logic [31:0]      av_readdata,
  output logic             av_waitrequest,
  input  wire logic [5:0]  pin_in,
  output gp6_pad_t         pad,
  input  wire logic        ir_carrier_in,
  input  wire logic        pwm_wave_in,
  input  wire logic        buzzer_wave_in,
  input  wire logic        inst_clk_level,
  input  wire logic [1:0]  op_mode,
  output logic             timer_a_ext_clk,
  output logic             timer_b_ext_clk,
  output logic             ext_reset_n,
  output logic             int_req,
  output logic             irq
);

  // ============================================================
  // reset release
  // ============================================================
  logic rst_meta_reg;
  logic rst_n_reg;

  // async assert, release after two edges so no flop sees a runt
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ============================================================
  // register decode
  // ============================================================
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  gp6_state_t st_reg;
  gp6_state_t st_next;
  logic       wr_go;
  logic [7:0] wd;
  logic [5:0] alt_en;
  logic [5:0] alt_val;
  logic [5:0] drv_val;
  logic [5:0] is_out;
  logic [5:0] od_eff;
  logic [5:0] lc_mask;
  logic       lc_event;
  logic       ext_event;
  logic       ext_int_select;
  logic       fixed_in3;

  // write lands on the edge where waitrequest is seen low
  assign wr_go = av_req.write && st_reg.ack && av_req.byteenable[0];
  assign wd    = av_req.writedata[7:0];
  assign ext_int_select = st_reg.power[BIT_EXT_SELECT];
  assign fixed_in3 = st_reg.config_opt[BIT_CFG_EXT_RST];

  // ============================================================
  // pin alternate functions
  // ============================================================
  always_comb
  begin
    alt_en  = 6'h00;
    alt_val = 6'h00;
    // carrier gated by latch data, polarity from ir ctrl
    alt_en[1]  = st_reg.ir_ctrl[BIT_IR_ENABLE];
    alt_val[1] = ir_carrier_in &
                 (st_reg.port_data[1] ^ st_reg.ir_ctrl[BIT_IR_POLARITY]);
    // pwm takes precedence if both options were picked
    if (st_reg.tmr_b_ctrl[BIT_PWM_ENABLE] &&
        st_reg.config_opt[BIT_CFG_PIN2_PWM])
    begin
      alt_en[2]  = 1'b1;
      alt_val[2] = pwm_wave_in;
    end
    else if (st_reg.buzz_ctrl[BIT_BUZZ_ENABLE] &&
             st_reg.config_opt[BIT_CFG_PIN2_BUZZ])
    begin
      alt_en[2]  = 1'b1;
      alt_val[2] = buzzer_wave_in;
    end
    alt_en[4]  = st_reg.config_opt[BIT_CFG_CLK_OUT] &&
                 (op_mode == MODE_NORMAL ||
                  op_mode == MODE_STANDBY);
    alt_val[4] = inst_clk_level;
  end

  // ============================================================
  // pad drivers, one slice per pin
  // ============================================================
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pad
      // direction bit high means input
      assign is_out[gi]  = alt_en[gi] ||
                           (!st_reg.direction[gi] &&
                            !(gi == OD_FIXED_PIN && fixed_in3));
      assign drv_val[gi] = alt_en[gi] ? alt_val[gi]
                                      : st_reg.port_data[gi];
      assign od_eff[gi]  = st_reg.open_drain[gi] ||
                           (gi == OD_FIXED_PIN);
      // open drain only pulls low, released high
      assign pad.oe[gi]  = is_out[gi] && (!od_eff[gi] || !drv_val[gi]);
      assign pad.out[gi] = drv_val[gi];
      assign pad.pull_up[gi] = !is_out[gi] && st_reg.pull_up[gi];
      if (gi < 4)
      begin : g_pd
        assign pad.pull_down[gi] = !is_out[gi] &&
                                   st_reg.pull_down[gi];
      end
    end
  endgenerate

  // ============================================================
  // pin-driven side outputs
  // ============================================================
  // only synchronised levels leave the block
  assign ext_reset_n = !(fixed_in3 && !st_reg.sync_b[3]);
  assign timer_a_ext_clk = st_reg.sync_b[2] &&
                           st_reg.tmr_sel[BIT_TA_CLK_SEL] &&
                           !st_reg.tmr_sel[BIT_TA_LOW_OSC];
  assign timer_b_ext_clk = st_reg.sync_b[2] &&
                           st_reg.tmr_sel[BIT_TB_CLK_SEL];

  // ============================================================
  // change and edge detection
  // ============================================================
  // pin 0 is dropped from change watching while it is the ext input
  assign lc_mask   = st_reg.wakeup & ~{5'h00, ext_int_select};
  assign lc_event  = |((st_reg.sync_b ^ st_reg.prev) & lc_mask);
  assign ext_event = ext_int_select &&
                     (st_reg.config_opt[BIT_CFG_EDGE_FALL]
                      ? (st_reg.prev[0] && !st_reg.sync_b[0])
                      : (!st_reg.prev[0] && st_reg.sync_b[0]));

  // ============================================================
  // interrupt outputs
  // ============================================================
  assign int_req = |(st_reg.int_flag & st_reg.int_enable) &&
                   st_reg.power_two[BIT_GLOBAL_EN];
  assign irq     = |(st_reg.evt_stat & st_reg.evt_mask);

  // ============================================================
  // avalon answer
  // ============================================================
  // one wait cycle: cheap decode, no combinational read path
  assign av_waitrequest = (av_req.read || av_req.write) && !st_reg.ack;
  assign av_readdata    = {24'h000000, st_reg.rdata};

  // ============================================================
  // next state
  // ============================================================
  always_comb
  begin
    st_next = st_reg;
    st_next.ack = (av_req.read || av_req.write) && !st_reg.ack;
    // two stages, then one more for the previous sample
    st_next.sync_a = pin_in;
    st_next.sync_b = st_reg.sync_a;
    st_next.prev   = st_reg.sync_b;

    // read capture in the wait cycle
    if (av_req.read && !st_reg.ack)
    begin
      st_next.rdata = 8'h00;
      case (av_req.address)
        OFS_PORT_DATA:  st_next.rdata = {2'h0,
          (st_reg.read_type & st_reg.port_data) |
          (~st_reg.read_type & st_reg.sync_b)};
        OFS_DIRECTION:  st_next.rdata = {2'h0, st_reg.direction};
        OFS_PULL_UP:    st_next.rdata = {2'h0, st_reg.pull_up};
        OFS_PULL_DOWN:  st_next.rdata = {st_reg.pull_down, 4'h0};
        OFS_OPEN_DRAIN: st_next.rdata = {2'h0, st_reg.open_drain};
        OFS_WAKEUP:     st_next.rdata = {2'h0, st_reg.wakeup};
        OFS_INT_FLAG:   st_next.rdata = {5'h00, st_reg.int_flag, 1'b0};
        OFS_INT_ENABLE: st_next.rdata = {5'h00, st_reg.int_enable, 1'b0};
        OFS_POWER:      st_next.rdata = st_reg.power;
        OFS_POWER_TWO:  st_next.rdata = st_reg.power_two;
        OFS_IR_CTRL:    st_next.rdata = {5'h00, st_reg.ir_ctrl};
        OFS_TMR_B_CTRL: st_next.rdata = st_reg.tmr_b_ctrl;
        OFS_BUZZ_CTRL:  st_next.rdata = st_reg.buzz_ctrl;
        OFS_TMR_SEL:    st_next.rdata = {5'h00, st_reg.tmr_sel};
        OFS_READ_TYPE:  st_next.rdata = {2'h0, st_reg.read_type};
        OFS_CONFIG:     st_next.rdata = st_reg.config_opt;
        OFS_EVT_STAT:   st_next.rdata = {5'h00, st_reg.evt_stat, 1'b0};
        OFS_EVT_MASK:   st_next.rdata = {5'h00, st_reg.evt_mask, 1'b0};
        default:        st_next.rdata = 8'h00;
      endcase
    end

    // plain register writes
    if (wr_go)
    begin
      if (hit(av_req.address, OFS_PORT_DATA))  st_next.port_data  = wd[5:0];
      if (hit(av_req.address, OFS_DIRECTION))  st_next.direction  = wd[5:0];
      if (hit(av_req.address, OFS_PULL_UP))    st_next.pull_up    = wd[5:0];
      if (hit(av_req.address, OFS_PULL_DOWN))  st_next.pull_down  = wd[7:4];
      if (hit(av_req.address, OFS_OPEN_DRAIN)) st_next.open_drain = wd[5:0];
      if (hit(av_req.address, OFS_WAKEUP))     st_next.wakeup     = wd[5:0];
      if (hit(av_req.address, OFS_INT_ENABLE)) st_next.int_enable = wd[2:1];
      if (hit(av_req.address, OFS_POWER))      st_next.power      = wd;
      if (hit(av_req.address, OFS_POWER_TWO))  st_next.power_two  = wd;
      if (hit(av_req.address, OFS_IR_CTRL))    st_next.ir_ctrl    = wd[2:0];
      if (hit(av_req.address, OFS_TMR_B_CTRL)) st_next.tmr_b_ctrl = wd;
      if (hit(av_req.address, OFS_BUZZ_CTRL))  st_next.buzz_ctrl  = wd;
      if (hit(av_req.address, OFS_TMR_SEL))    st_next.tmr_sel    = wd[2:0];
      if (hit(av_req.address, OFS_READ_TYPE))  st_next.read_type  = wd[5:0];
      if (hit(av_req.address, OFS_CONFIG))     st_next.config_opt = wd;
      if (hit(av_req.address, OFS_EVT_MASK))   st_next.evt_mask   = wd[2:1];
    end

    // flags: a zero written clears, a fresh event still wins
    if (wr_go && hit(av_req.address, OFS_INT_FLAG))
      st_next.int_flag = st_reg.int_flag & wd[2:1];
    st_next.int_flag[BIT_LEVEL_CHANGE] =
      st_next.int_flag[BIT_LEVEL_CHANGE] | lc_event;
    st_next.int_flag[BIT_EXT_INT] =
      st_next.int_flag[BIT_EXT_INT] | ext_event;

    // event status: write one to clear, set still wins
    if (wr_go && hit(av_req.address, OFS_EVT_STAT))
      st_next.evt_stat = st_reg.evt_stat & ~wd[2:1];
    st_next.evt_stat = st_next.evt_stat | {ext_event, lc_event};
  end

  // ============================================================
  // state register
  // ============================================================
  always_ff @(posedge ref_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      st_reg           <= '0;
      st_reg.direction <= RST_DIRECTION;
      st_reg.buzz_ctrl <= RST_BUZZ_CTRL;
      st_reg.config_opt <= RST_CONFIG;
    end
    else
      st_reg <= st_next;
  end

  // ============================================================
  // checks
  // ============================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_reg);

  property p_dir_input;
    st_reg.direction[5] |-> !pad.oe[5];
  endproperty
  a_dir_input: assert property (p_dir_input)
    else $error("input pin 5 is driven");

  property p_pull_up;
    (st_reg.direction[5] && st_reg.pull_up[5]) |-> pad.pull_up[5];
  endproperty
  a_pull_up: assert property (p_pull_up)
    else $error("pull-up missing on input pin 5");

  property p_pull_down;
    pad.pull_down[0] |-> (st_reg.pull_down[0] && !pad.oe[0]);
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pull-down on pin 0 without cause");

  property p_od_pin3;
    pad.oe[3] |-> !pad.out[3];
  endproperty
  a_od_pin3: assert property (p_od_pin3)
    else $error("pin 3 drives high");

  property p_lc_flag;
    (st_reg.wakeup[5] && (st_reg.sync_b[5] != st_reg.prev[5]))
      |=> st_reg.int_flag[BIT_LEVEL_CHANGE];
  endproperty
  a_lc_flag: assert property (p_lc_flag)
    else $error("level change did not set flag");

  property p_int_req;
    int_req |-> (st_reg.power_two[BIT_GLOBAL_EN] &&
                 |(st_reg.int_flag & st_reg.int_enable));
  endproperty
  a_int_req: assert property (p_int_req)
    else $error("interrupt request without cause");

  property p_pin0_masked;
    // pins 5..1 quiet, so only a pin 0 change could set the flag
    (ext_int_select && st_reg.sync_b[5:1] == st_reg.prev[5:1] &&
     !st_reg.int_flag[BIT_LEVEL_CHANGE] &&
     !(wr_go && hit(av_req.address, OFS_INT_FLAG)))
      |=> !st_reg.int_flag[BIT_LEVEL_CHANGE];
  endproperty
  a_pin0_masked: assert property (p_pin0_masked)
    else $error("pin 0 change counted while ext input");

  property p_ir_out;
    (st_reg.ir_ctrl == 3'h1 && st_reg.port_data[1] && ir_carrier_in)
      |-> (pad.oe[1] || st_reg.open_drain[1]) && pad.out[1];
  endproperty
  a_ir_out: assert property (p_ir_out)
    else $error("ir carrier missing on pin 1");

  property p_ext_reset;
    (fixed_in3 && !st_reg.sync_b[3]) |-> !ext_reset_n;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("pin 3 low did not reset");

  property p_sync_delay;
    ##2 st_reg.sync_b == $past(pin_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser delay is not two cycles");

  property p_wait_once;
    (av_req.read || av_req.write) && av_waitrequest |=> !av_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("bus answer later than one wait cycle");

  property p_ext_int;
    (ext_int_select && !st_reg.config_opt[BIT_CFG_EDGE_FALL] &&
     !st_reg.prev[0] && st_reg.sync_b[0])
      |=> st_reg.int_flag[BIT_EXT_INT];
  endproperty
  a_ext_int: assert property (p_ext_int)
    else $error("pin 0 rising edge did not set ext flag");

  // halt mode must not leak the clock onto an input pin
  property p_clk_halt;
    (st_reg.direction[4] && op_mode == 2'h1) |-> !pad.oe[4];
  endproperty
  a_clk_halt: assert property (p_clk_halt)
    else $error("clock driven on pin 4 in halt mode");

  property p_od_pin0;
    (st_reg.open_drain[0] && pad.oe[0]) |-> !pad.out[0];
  endproperty
  a_od_pin0: assert property (p_od_pin0)
    else $error("open-drain pin 0 drives high");

  c_lc_irq:  cover property (lc_event ##1 int_req);
  c_ext_int: cover property (ext_event);
  c_pwm_pin: cover property (alt_en[2] && pad.oe[2]);
  c_rd_port: cover property (av_req.read &&
                             av_req.address == OFS_PORT_DATA && st_reg.ack);

endmodule

// file: core/gp6_pkg.sv
// ============================================================
// shared constants and carriers for the six-pin port
// ============================================================
package gp6_pkg;

  localparam int NPIN = 6;

  // ============================================================
  // register byte offsets on the avalon slave
  // ============================================================
  localparam logic [5:0] OFS_PORT_DATA  = 6'h00;
  localparam logic [5:0] OFS_DIRECTION  = 6'h04;
  localparam logic [5:0] OFS_PULL_UP    = 6'h08;
  localparam logic [5:0] OFS_PULL_DOWN  = 6'h0C;
  localparam logic [5:0] OFS_OPEN_DRAIN = 6'h10;
  localparam logic [5:0] OFS_WAKEUP     = 6'h14;
  localparam logic [5:0] OFS_INT_FLAG   = 6'h18;
  localparam logic [5:0] OFS_INT_ENABLE = 6'h1C;
  localparam logic [5:0] OFS_POWER      = 6'h20;
  localparam logic [5:0] OFS_POWER_TWO  = 6'h24;
  localparam logic [5:0] OFS_IR_CTRL    = 6'h28;
  localparam logic [5:0] OFS_TMR_B_CTRL = 6'h2C;
  localparam logic [5:0] OFS_BUZZ_CTRL  = 6'h30;
  localparam logic [5:0] OFS_TMR_SEL    = 6'h34;
  localparam logic [5:0] OFS_READ_TYPE  = 6'h38;
  localparam logic [5:0] OFS_CONFIG     = 6'h3C;
  localparam logic [5:0] OFS_EVT_STAT   = 6'h40;
  localparam logic [5:0] OFS_EVT_MASK   = 6'h44;

  // ============================================================
  // field positions
  // ============================================================
  localparam int BIT_LEVEL_CHANGE = 1;  // int flag / enable
  localparam int BIT_EXT_INT      = 2;
  localparam int BIT_EXT_SELECT   = 6;  // power ctrl
  localparam int BIT_GLOBAL_EN    = 7;  // power ctrl two
  localparam int BIT_IR_ENABLE    = 0;  // ir ctrl
  localparam int BIT_IR_POLARITY  = 2;
  localparam int BIT_PWM_ENABLE   = 7;  // timer b ctrl
  localparam int BIT_BUZZ_ENABLE  = 7;  // buzzer ctrl
  localparam int BIT_TA_CLK_SEL   = 0;  // timer select
  localparam int BIT_TA_LOW_OSC   = 1;
  localparam int BIT_TB_CLK_SEL   = 2;
  localparam int BIT_CFG_EXT_RST  = 0;  // configuration options
  localparam int BIT_CFG_CLK_OUT  = 1;
  localparam int BIT_CFG_PIN2_PWM  = 2;
  localparam int BIT_CFG_PIN2_BUZZ = 3;
  localparam int BIT_CFG_EDGE_FALL = 4;
  localparam int PULL_DOWN_LSB    = 4;
  localparam int OD_FIXED_PIN     = 3;

  // ============================================================
  // reset values and operating modes
  // ============================================================
  localparam logic [5:0] RST_DIRECTION = 6'h3F;  // all inputs
  localparam logic [7:0] RST_BUZZ_CTRL = 8'h0F;
  localparam logic [7:0] RST_CONFIG    = 8'h00;
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_STANDBY  = 2'h2;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } gp6_av_req_t;

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pull_up;
    logic [3:0] pull_down;
  } gp6_pad_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic [5:0] port_data;
    logic [5:0] direction;
    logic [5:0] pull_up;
    logic [3:0] pull_down;
    logic [5:0] open_drain;
    logic [5:0] wakeup;
    logic [2:1] int_flag;
    logic [2:1] int_enable;
    logic [7:0] power;
    logic [7:0] power_two;
    logic [2:0] ir_ctrl;
    logic [7:0] tmr_b_ctrl;
    logic [7:0] buzz_ctrl;
    logic [2:0] tmr_sel;
    logic [5:0] read_type;
    logic [7:0] config_opt;
    logic [2:1] evt_stat;
    logic [2:1] evt_mask;
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic [5:0] prev;
  } gp6_state_t;

endpackage

// file: bench/gp6_board.sv
`timescale 1ns/1ps
// ============================================================
// board side of the six port pins
// ============================================================
module gp6_board
  import gp6_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire gp6_pad_t   pad,
  input  wire logic [5:0] drv_en,
  input  wire logic [5:0] drv_val,
  output logic [5:0]      pin_level
);
  logic [5:0] float_reg;

  // undriven pins keep their last level, high if never driven, so they never read as X
  always_ff @(posedge ref_clk)
  begin
    float_reg <= ~pin_level;
  end

  // pad wins, then board, then pulls; pins 4,5 have no pull-down
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pad.oe[i])
        pin_level[i] = pad.out[i];
      else if (drv_en[i])
        pin_level[i] = drv_val[i];
      else if (pad.pull_up[i])
        pin_level[i] = 1'b1;
      else if (i < 4 && pad.pull_down[i % 4])
        pin_level[i] = 1'b0;
      else
        pin_level[i] = (float_reg[i] === 1'b1) ? 1'b0 : 1'b1;
    end
  end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb
  import gp6_pkg::*;
;
  logic        ref_clk;
  logic        nrst;
  gp6_av_req_t av_req;
  logic [31:0] av_readdata;
  logic        av_waitrequest;
  logic [5:0]  pin_in;
  gp6_pad_t    pad;
  logic        pwm_wave_in;
  logic        ir_carrier_in;
  logic        buzzer_wave_in;
  logic [1:0]  op_mode;
  logic        inst_clk_level;
  logic        timer_a_ext_clk;
  logic        timer_b_ext_clk;
  logic        ext_reset_n;
  logic        int_req;
  logic        irq;
  logic [5:0]  drv_en;
  logic [5:0]  drv_val;
  logic [31:0] q;
  int          num_errors;
  int          checked;

  gp6_port dut (.ref_clk(ref_clk), .nrst(nrst), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .pin_in(pin_in), .pad(pad), .ir_carrier_in(ir_carrier_in),
    .pwm_wave_in(pwm_wave_in), .buzzer_wave_in(buzzer_wave_in),
    .inst_clk_level(inst_clk_level), .op_mode(op_mode),
    .timer_a_ext_clk(timer_a_ext_clk), .timer_b_ext_clk(timer_b_ext_clk),
    .ext_reset_n(ext_reset_n), .int_req(int_req), .irq(irq));

  gp6_board board (.ref_clk(ref_clk), .pad(pad), .drv_en(drv_en),
    .drv_val(drv_val), .pin_level(pin_in));

  // ============================================================
  // clock, report and bus tasks
  // ============================================================
  always #50 ref_clk = ~ref_clk;

  task automatic results();
    $display("compares %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    av_req <= '{a, ~w, w, {24'h0, d}, 4'hF};
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      if (av_waitrequest === 1'b0)
        break;
    end
    if (n == 20)
      check("waitrequest", 32'h0, 32'h1);
    q = av_readdata;
    av_req <= '0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [5:0] a,
                    input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(nm, {24'h0, e}, q & {24'h0, m});
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ============================================================
  // scenarios
  // ============================================================
  task automatic t_reset();
    rd("direction", OFS_DIRECTION, 8'hFF, 8'h3F);
    rd("unmapped", 6'h02, 8'hFF, 8'h00);
    @(negedge ref_clk);
    check("oe", 32'h0, {26'h0, pad.oe});
    check("ext_reset_n", 32'h1, {31'h0, ext_reset_n});
  endtask

  // pin 3 is open-drain regardless; pin 0 open-drain by choice
  task automatic t_output();
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_PORT_DATA, 8'h2A);
    wr(OFS_OPEN_DRAIN, 8'h01);
    wr(OFS_READ_TYPE, 8'h3F);
    @(negedge ref_clk);
    check("oe", 32'h37, {26'h0, pad.oe});
    check("out", 32'h22, {26'h0, pad.out & pad.oe});
    rd("latch", OFS_PORT_DATA, 8'h3F, 8'h2A);
    wr(OFS_READ_TYPE, 8'h00);
    settle();
    rd("pins", OFS_PORT_DATA, 8'h3F, 8'h22);
    wr(OFS_DIRECTION, 8'h3F);
    wr(OFS_OPEN_DRAIN, 8'h00);
  endtask

  task automatic t_pulls();
    drv_en <= 6'h00;
    wr(OFS_PULL_UP, 8'h15);
    wr(OFS_PULL_DOWN, 8'hA0);
    settle();
    check("pull_up", 32'h15, {26'h0, pad.pull_up});
    check("pull_down", 32'hA, {28'h0, pad.pull_down});
    rd("pulled", OFS_PORT_DATA, 8'h1F, 8'h15);
    wr(OFS_DIRECTION, 8'h3E);
    @(negedge ref_clk);
    check("pull_up out", 32'h14, {26'h0, pad.pull_up});
    wr(OFS_DIRECTION, 8'h3F);
    drv_en <= 6'h3F;
    wr(OFS_PULL_UP, 8'h00);
    wr(OFS_PULL_DOWN, 8'h00);
  endtask

  task automatic t_level();
    int n;
    wr(OFS_WAKEUP, 8'h21);
    wr(OFS_INT_ENABLE, 8'h02);
    wr(OFS_POWER_TWO, 8'h80);
    wr(OFS_POWER, 8'h40);
    settle();
    wr(OFS_INT_FLAG, 8'h00);
    drv_val[0] <= 1'b1;
    settle();
    rd("pin0 masked", OFS_INT_FLAG, 8'h06, 8'h04);
    drv_val[5] <= 1'b1;
    for (n = 0; n < 8 && int_req !== 1'b1; n++)
      @(negedge ref_clk);
    check("int_req", 32'h1, {31'h0, int_req});
    rd("flag", OFS_INT_FLAG, 8'h02, 8'h02);
    wr(OFS_INT_FLAG, 8'h00);
    @(negedge ref_clk);
    check("int_req clr", 32'h0, {31'h0, int_req});
    wr(OFS_POWER_TWO, 8'h00);
    drv_val[5] <= 1'b0;
    settle();
    check("int_req gie", 32'h0, {31'h0, int_req});
    rd("sticky", OFS_INT_FLAG, 8'h02, 8'h02);
  endtask

  task automatic t_alt();
    drv_val <= 6'h04;
    wr(OFS_TMR_SEL, 8'h04);
    settle();
    check("tb clk", 32'h1, {31'h0, timer_b_ext_clk});
    wr(OFS_TMR_SEL, 8'h01);
    @(negedge ref_clk);
    check("ta clk", 32'h1, {31'h0, timer_a_ext_clk});
    wr(OFS_TMR_SEL, 8'h03);
    @(negedge ref_clk);
    check("ta low osc", 32'h0, {31'h0, timer_a_ext_clk});
    wr(OFS_CONFIG, 8'h06);
    wr(OFS_TMR_B_CTRL, 8'h80);
    wr(OFS_IR_CTRL, 8'h01);
    @(negedge ref_clk);
    check("pwm", 32'h1, {31'h0, pad.oe[2] & pad.out[2]});
    check("clk out", 32'h3, {30'h0, pad.oe[4], pad.out[4]});
    check("ir", 32'h1, {31'h0, pad.oe[1]});
    // pwm low and buzzer high, so only the buzzer path reads one
    wr(OFS_BUZZ_CTRL, 8'h8F);
    wr(OFS_CONFIG, 8'h0A);
    buzzer_wave_in <= 1'b1;
    pwm_wave_in    <= 1'b0;
    ir_carrier_in  <= 1'b0;
    op_mode        <= 2'h1;
    @(negedge ref_clk);
    check("buzzer", 32'h1, {31'h0, pad.oe[2] & pad.out[2]});
    check("ir off", 32'h2, {30'h0, pad.oe[1], pad.out[1]});
    check("clk halt", 32'h0, {31'h0, pad.oe[4]});
    @(posedge ref_clk);
    op_mode <= MODE_STANDBY;
    @(negedge ref_clk);
    check("clk standby", 32'h1, {31'h0, pad.oe[4]});
    wr(OFS_CONFIG, 8'h01);
    settle();
    check("ext rst", 32'h0, {31'h0, ext_reset_n});
    drv_val[3] <= 1'b1;
    settle();
    check("ext rst off", 32'h1, {31'h0, ext_reset_n});
  endtask

  // level-change status bit is still set from the t_level scenario
  task automatic t_irq();
    wr(OFS_EVT_MASK, 8'h02);
    @(negedge ref_clk);
    check("irq", 32'h1, {31'h0, irq});
    wr(OFS_EVT_MASK, 8'h00);
    @(negedge ref_clk);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_EVT_MASK, 8'h02);
    wr(OFS_EVT_STAT, 8'h02);
    @(negedge ref_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
  endtask

  // ============================================================
  // main sequence and watchdog
  // ============================================================
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    av_req = '0;
    pwm_wave_in = 1'b1;
    ir_carrier_in = 1'b1;
    buzzer_wave_in = 1'b0;
    op_mode = MODE_NORMAL;
    inst_clk_level = 1'b1;
    drv_en = 6'h3F;
    drv_val = 6'h00;
    num_errors = 0;
    checked = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_output();
    t_pulls();
    t_level();
    t_alt();
    t_irq();
    results();
  end

  // whole run is a few hundred cycles; this leaves ample margin
  initial
  begin
    #(100 * 5000);
    num_errors++;
    results();
  end
endmodule
